//--- inc/flash_host_pkg.sv
// constants, command and pin carriers for the flash host controller
// assumes one 100 MHz clock; the flash pins are sampled through a three-stage synchroniser
// Functional notes
// - identification entry: AA/555, 55/2AA, 90/555
// - identification exit: F0 to any address
// - writes: chip select, strobe low, enable high
// - hardware reset aborts; host reissues sequence
// - program: AA, 55, A0, then data
package flash_host_pkg;
   localparam int ADDR_W = 26;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] WORD_UNLOCK1 = 26'h0000555;
   localparam logic [ADDR_W-1:0] WORD_UNLOCK2 = 26'h00002AA;
   localparam logic [ADDR_W-1:0] BYTE_UNLOCK1 = 26'h0000AAA;
   localparam logic [ADDR_W-1:0] BYTE_UNLOCK2 = 26'h0000555;
   localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 16'h00AA;
   localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 16'h0055;
   localparam logic [DATA_W-1:0] CODE_ID_ENTRY = 16'h0090;
   localparam logic [DATA_W-1:0] CODE_RESET = 16'h00F0;
   localparam logic [DATA_W-1:0] CODE_PROG_SETUP = 16'h00A0;
   localparam int DQ_TOGGLE_BIT = 6;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_WE_LOW_NS = 35;
   localparam int T_WE_HIGH_NS = 20;
   localparam int T_READ_ACC_NS = 110;
   localparam int PROG_TIMEOUT_US = 200;
   localparam int WE_LOW_RAW = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_HIGH_RAW = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_LOW_CYC = (WE_LOW_RAW < 1) ? 1 : WE_LOW_RAW;
   localparam int WE_HIGH_CYC = (WE_HIGH_RAW < 1) ? 1 : WE_HIGH_RAW;
   localparam int READ_CYC = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1;
   localparam int PROG_TIMEOUT_CYC = PROG_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam int TMO_W = 24;
   localparam logic [DATA_W-1:0] DQ_RESET = 16'h0000;

   typedef enum logic [1:0] {OP_READ, OP_ID_ENTER, OP_ID_EXIT, OP_PROGRAM} host_op_t;

   typedef struct packed {
      host_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } host_cmd_t;

   typedef struct packed {
      logic err;
      logic [DATA_W-1:0] data;
   } host_rsp_t;

   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } flash_pins_t;
endpackage

//--- design/pin_sync.sv
// three-stage synchroniser for pins that change outside the clock domain
// assumes the pins are quiet long enough for two late stages to agree
`timescale 1ns/1ns
module pin_sync
   import flash_host_pkg::*;
#(
   parameter int W = DATA_W
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] stable
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_stable;

   // a change counts only once the second and third stages agree
   always_comb begin
      next_stable = (s2 == s3) ? s3 : stable;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         stable <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         stable <= next_stable;
      end
   end
endmodule

//--- design/flash_host_ctrl.sv
// host-side controller driving a parallel nor flash: identification entry and exit,
// array and identification reads, single word program with toggle polling
// assumes the flash dq pins arrive unsynchronised and byte_mode is static per command
`timescale 1ns/1ns
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int PROG_TIMEOUT = PROG_TIMEOUT_CYC
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic byte_mode,
   input wire logic cmd_valid,
   input wire host_cmd_t cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output host_rsp_t rsp,
   output logic id_mode,
   output logic prog_busy,
   output logic flash_rst_n,
   output flash_pins_t pins,
   input wire logic [DATA_W-1:0] dq_in
);
   typedef enum logic [2:0] {ST_IDLE, ST_W_ADDR, ST_W_LOW, ST_W_HIGH, ST_GAP, ST_R_WAIT, ST_R_TURN} host_state_t;

   host_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [1:0] step, next_step;
   host_cmd_t cur, next_cur;
   logic have_prev, next_have_prev;
   logic prev_tog, next_prev_tog;
   logic [TMO_W-1:0] tmo, next_tmo;
   logic next_cmd_ready, next_rsp_valid, next_id_mode, next_prog_busy;
   host_rsp_t next_rsp;
   flash_pins_t next_pins;
   logic [DATA_W-1:0] dq_sync;
   logic [DATA_W-1:0] rd;
   logic finish, fin_err, go_write, go_read;
   logic [DATA_W-1:0] fin_data;

   pin_sync #(.W(DATA_W)) u_dq_sync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .raw(dq_in),
      .stable(dq_sync)
   );

   function automatic logic [ADDR_W-1:0] unlock_addr(input logic first, input logic bm);
      if (first)
         return bm ? BYTE_UNLOCK1 : WORD_UNLOCK1;
      else
         return bm ? BYTE_UNLOCK2 : WORD_UNLOCK2;
   endfunction

   // address of each write cycle of a command sequence
   function automatic logic [ADDR_W-1:0] seq_addr(input host_op_t op, input logic [1:0] st, input logic bm,
                                                  input logic [ADDR_W-1:0] target);
      if (op == OP_ID_EXIT || st == 2'd3)
         return target;
      else
         return unlock_addr(st != 2'd1, bm);
   endfunction

   // data of each write cycle; byte mode drives the high lane as zeros
   function automatic logic [DATA_W-1:0] seq_data(input host_op_t op, input logic [1:0] st, input logic bm,
                                                  input logic [DATA_W-1:0] value);
      logic [DATA_W-1:0] d;
      d = value;
      case (st)
         2'd0: d = (op == OP_ID_EXIT) ? CODE_RESET : CODE_UNLOCK1;
         2'd1: d = CODE_UNLOCK2;
         2'd2: d = (op == OP_PROGRAM) ? CODE_PROG_SETUP : CODE_ID_ENTRY;
         default: d = value;
      endcase
      return bm ? {8'h00, d[7:0]} : d;
   endfunction

   function automatic logic [1:0] last_step(input host_op_t op);
      case (op)
         OP_ID_ENTER: return 2'd2;
         OP_PROGRAM: return 2'd3;
         default: return 2'd0;
      endcase
   endfunction

   assign rd = byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_step = step;
      next_cur = cur;
      next_have_prev = have_prev;
      next_prev_tog = prev_tog;
      next_tmo = prog_busy ? tmo + 1'b1 : tmo;
      next_cmd_ready = cmd_ready;
      next_rsp_valid = 1'b0;
      next_rsp = rsp;
      next_id_mode = id_mode;
      next_prog_busy = prog_busy;
      next_pins = pins;
      finish = 1'b0;
      fin_err = 1'b0;
      fin_data = '0;
      go_write = 1'b0;
      go_read = 1'b0;
      case (state)
         ST_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               next_cur = cmd;
               next_step = 2'd0;
               next_cmd_ready = 1'b0;
               if (cmd.op == OP_PROGRAM && id_mode) begin
                  finish = 1'b1;
                  fin_err = 1'b1;
               end else if (cmd.op == OP_READ) begin
                  go_read = 1'b1;
               end else begin
                  go_write = 1'b1;
               end
            end
         end
         ST_W_ADDR: begin
            next_pins.we_n = 1'b0;
            next_cnt = CNT_W'(WE_LOW_CYC - 1);
            next_state = ST_W_LOW;
         end
         ST_W_LOW: begin
            if (cnt == '0) begin
               next_pins.we_n = 1'b1;
               next_state = ST_W_HIGH;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_W_HIGH: begin
            next_pins.ce_n = 1'b1;
            next_pins.dq_oe = 1'b0;
            next_cnt = CNT_W'(WE_HIGH_CYC - 1);
            next_state = ST_GAP;
         end
         ST_GAP: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else if (step != last_step(cur.op)) begin
               next_step = step + 1'b1;
               go_write = 1'b1;
            end else begin
               case (cur.op)
                  OP_ID_ENTER: begin
                     next_id_mode = 1'b1;
                     finish = 1'b1;
                  end
                  OP_ID_EXIT: begin
                     next_id_mode = 1'b0;
                     finish = 1'b1;
                  end
                  default: begin
                     // the fourth cycle starts the internal algorithm; poll the target
                     next_prog_busy = 1'b1;
                     next_have_prev = 1'b0;
                     next_tmo = '0;
                     go_read = 1'b1;
                  end
               endcase
            end
         end
         ST_R_WAIT: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else if (!prog_busy) begin
               finish = 1'b1;
               fin_data = rd;
            end else if (have_prev && prev_tog == rd[DQ_TOGGLE_BIT]) begin
               // toggle bit stopped: array read mode is back
               next_prog_busy = 1'b0;
               finish = 1'b1;
               fin_data = rd;
            end else if (tmo >= TMO_W'(PROG_TIMEOUT)) begin
               next_prog_busy = 1'b0;
               finish = 1'b1;
               fin_err = 1'b1;
               fin_data = rd;
            end else begin
               next_have_prev = 1'b1;
               next_prev_tog = rd[DQ_TOGGLE_BIT];
               next_pins.ce_n = 1'b1;
               next_pins.oe_n = 1'b1;
               next_state = ST_R_TURN;
            end
         end
         ST_R_TURN: begin
            go_read = 1'b1;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (go_write) begin
         next_pins.ce_n = 1'b0;
         next_pins.we_n = 1'b1;
         next_pins.oe_n = 1'b1;
         next_pins.addr = seq_addr(next_cur.op, next_step, byte_mode, next_cur.addr);
         next_pins.dq_out = seq_data(next_cur.op, next_step, byte_mode, next_cur.data);
         next_pins.dq_oe = 1'b1;
         next_state = ST_W_ADDR;
      end
      if (go_read) begin
         next_pins.ce_n = 1'b0;
         next_pins.we_n = 1'b1;
         next_pins.oe_n = 1'b0;
         next_pins.addr = next_cur.addr;
         next_pins.dq_oe = 1'b0;
         next_cnt = CNT_W'(READ_CYC - 1);
         next_state = ST_R_WAIT;
      end
      if (finish) begin
         next_pins.ce_n = 1'b1;
         next_pins.we_n = 1'b1;
         next_pins.oe_n = 1'b1;
         next_pins.dq_oe = 1'b0;
         next_rsp_valid = 1'b1;
         next_rsp = '{err: fin_err, data: fin_data};
         next_cmd_ready = 1'b1;
         next_state = ST_IDLE;
      end
   end

   // reset returns the pins to idle and forgets any program or identification state
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         cnt <= '0;
         step <= 2'd0;
         cur <= '0;
         have_prev <= 1'b0;
         prev_tog <= 1'b0;
         tmo <= '0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
         id_mode <= 1'b0;
         prog_busy <= 1'b0;
         flash_rst_n <= 1'b0;
         pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: DQ_RESET, dq_oe: 1'b0};
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         step <= next_step;
         cur <= next_cur;
         have_prev <= next_have_prev;
         prev_tog <= next_prev_tog;
         tmo <= next_tmo;
         cmd_ready <= (state == ST_IDLE && !flash_rst_n) ? 1'b1 : next_cmd_ready;
         rsp_valid <= next_rsp_valid;
         rsp <= next_rsp;
         id_mode <= next_id_mode;
         prog_busy <= next_prog_busy;
         flash_rst_n <= 1'b1;
         pins <= next_pins;
      end
   end

   a_write_strobes: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
      else $error("write strobe low without chip select, or with output enable");
   a_read_no_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !pins.oe_n |-> !pins.dq_oe && pins.we_n)
      else $error("data pins driven during a read");
   a_entry_cmd_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(pins.we_n) && cur.op == OP_ID_ENTER && step == 2'd2
      |-> pins.addr == unlock_addr(1'b1, byte_mode) && pins.dq_out[7:0] == CODE_ID_ENTRY[7:0])
      else $error("identification command at wrong address or code");
   a_entry_sets_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
      state == ST_GAP && cnt == '0 && cur.op == OP_ID_ENTER && step == 2'd2 |=> id_mode && rsp_valid)
      else $error("identification mode not entered after third cycle");
   a_exit_single_cycle: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(pins.we_n) && cur.op == OP_ID_EXIT |-> pins.dq_out[7:0] == CODE_RESET[7:0] && pins.addr == cur.addr
      ##[1:20] rsp_valid && !id_mode)
      else $error("exit command wrong or identification mode kept");
   a_prog_setup_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(pins.we_n) && cur.op == OP_PROGRAM && step == 2'd2
      |-> pins.addr == unlock_addr(1'b1, byte_mode) && pins.dq_out[7:0] == CODE_PROG_SETUP[7:0])
      else $error("program setup at wrong address or code");
   a_prog_then_poll: assert property (@(posedge sys_clk) disable iff (!arst_n)
      state == ST_GAP && cnt == '0 && cur.op == OP_PROGRAM && step == 2'd3
      |=> prog_busy && !pins.oe_n && pins.addr == cur.addr && pins.we_n [*8])
      else $error("polling did not start at the target after the data cycle");
   a_reset_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(flash_rst_n) |-> pins.ce_n && pins.we_n && !prog_busy && !id_mode && !rsp_valid)
      else $error("controller not idle after reset");

   c_entry_done: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(id_mode));
   c_prog_ok: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(prog_busy) && rsp_valid && !rsp.err);
   c_prog_timeout: cover property (@(posedge sys_clk) disable iff (!arst_n) rsp_valid && rsp.err && cur.op == OP_PROGRAM);
   c_id_read: cover property (@(posedge sys_clk) disable iff (!arst_n) rsp_valid && id_mode && cur.op == OP_READ);
endmodule

//--- verification/flash_model.sv
// behavioural parallel nor flash: command decoder, identification reads, word/byte program
// assumes the controller's pins struct and a dq multiplexer in the testbench, since dq is always driven
`timescale 1ns/1ns
module flash_model
   import flash_host_pkg::*;
#(
   parameter logic [DATA_W-1:0] MFR_CODE = 16'h005A, // arbitrary value
   parameter logic [DATA_W-1:0] SECURE_CODE = 16'h0099,
   parameter logic [3:0] LOCKED_SECTOR = 4'h2,
   parameter logic UNLOCK_SKIP = 1'b0,
   parameter int BUSY_NS = 1000
) (
   input wire flash_pins_t pins,
   input wire logic byte_mode,
   input wire logic rst_n,
   input wire logic stall,
   output logic [DATA_W-1:0] dq,
   output int proto_err
);
   logic [DATA_W-1:0] mem [0:255];
   logic [ADDR_W-1:0] lat_addr;
   logic [DATA_W-1:0] last;
   logic id;
   logic tog;
   int step;
   time busy_until;

   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {id, tog, step, busy_until, proto_err, last, lat_addr} = '0;
      dq = 16'hFFFF;
   end

   function automatic logic [DATA_W-1:0] id_word(input logic [ADDR_W-1:0] a);
      case (a[3:0])
         4'h0: return MFR_CODE;
         4'h2: return (a[7:4] == LOCKED_SECTOR) ? 16'h0001 : 16'h0000;
         4'h3: return SECURE_CODE;
         default: return 16'h0000;
      endcase
   endfunction

   task automatic decode(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [ADDR_W-1:0] u1;
      logic [ADDR_W-1:0] u2;
      u1 = byte_mode ? BYTE_UNLOCK1 : WORD_UNLOCK1;
      u2 = byte_mode ? BYTE_UNLOCK2 : WORD_UNLOCK2;
      if (byte_mode) d = {8'h00, d[7:0]};
      if ($time < busy_until) return;
      if (step == 3) begin
         mem[a[7:0]] = mem[a[7:0]] & (byte_mode ? {8'hFF, d[7:0]} : d);
         busy_until = $time + (stall ? 100 * BUSY_NS : BUSY_NS);
         step = 0;
      end else if (d == CODE_RESET) begin
         id = 1'b0;
         step = 0;
      end else if (UNLOCK_SKIP && step == 0 && d == CODE_PROG_SETUP) step = 3;
      else if (step == 0 && a == u1 && d == CODE_UNLOCK1) step = 1;
      else if (step == 1 && a == u2 && d == CODE_UNLOCK2) step = 2;
      else if (step == 2 && a == u1 && d == CODE_ID_ENTRY) begin
         id = 1'b1;
         step = 0;
      end else if (step == 2 && a == u1 && d == CODE_PROG_SETUP) step = 3;
      else step = 0;
   endtask

   always @(negedge pins.we_n or negedge pins.ce_n) begin
      if (!pins.we_n && !pins.ce_n) lat_addr = pins.addr;
   end

   always @(posedge pins.we_n or posedge pins.ce_n) begin
      if ((pins.we_n ^ pins.ce_n) && rst_n) begin
         if (!pins.oe_n || !pins.dq_oe) proto_err++;
         decode(lat_addr, pins.dq_out);
      end
   end

   always @(negedge rst_n) begin
      step = 0;
      id = 1'b0;
      busy_until = 0;
   end

   always @(negedge pins.oe_n) begin
      if ($time < busy_until) tog = ~tog;
   end

   // a released bus shows the inverse of the last value, never a held copy
   always @(pins.ce_n or pins.oe_n or pins.addr or tog or id) begin
      if (!pins.ce_n && !pins.oe_n) begin
         if (id) dq = id_word(pins.addr);
         else if ($time < busy_until) dq = {9'h000, tog, 6'h00};
         else dq = mem[pins.addr[7:0]];
         if (byte_mode) dq = {8'h00, dq[7:0]};
         last = dq;
      end else dq = ~last;
   end
endmodule

//--- verification/flash_host_ctrl_tb_top.sv
// self-checking bench for the flash host controller against the behavioural flash
// assumes the controller's assertions sit in its own files
`timescale 1ns/1ns
module flash_host_ctrl_tb_top
   import flash_host_pkg::*;
;
   localparam int PT = 200;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic byte_mode = 1'b0;
   logic cmd_valid = 1'b0;
   logic stall = 1'b0;
   host_cmd_t cmd = '0;
   logic cmd_ready, rsp_valid, id_mode, prog_busy, flash_rst_n, saw_busy;
   host_rsp_t rsp;
   host_rsp_t got;
   flash_pins_t pins;
   logic [DATA_W-1:0] flash_dq;
   logic [DATA_W-1:0] dq_in;
   int proto_err;
   int n_fail = 0;
   int total_checks = 0;

   assign dq_in = pins.dq_oe ? pins.dq_out : flash_dq;
   always #5 sys_clk = ~sys_clk;

   flash_host_ctrl #(.PROG_TIMEOUT(PT)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .byte_mode(byte_mode),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .id_mode(id_mode), .prog_busy(prog_busy), .flash_rst_n(flash_rst_n), .pins(pins), .dq_in(dq_in));
   flash_model u_flash (.pins(pins), .byte_mode(byte_mode), .rst_n(flash_rst_n), .stall(stall), .dq(flash_dq),
      .proto_err(proto_err));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic step_clk();
      @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [DATA_W-1:0] lane(input logic [DATA_W-1:0] v);
      return byte_mode ? {8'h00, v[7:0]} : v;
   endfunction

   // offers one command and, when asked, waits for its answer
   task automatic run(input host_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input bit wait_rsp = 1'b1);
      int i;
      i = 0;
      do begin
         step_clk();
         i++;
      end while (i < 50 && cmd_ready !== 1'b1);
      check(cmd_ready, 1'b1, "not ready");
      cmd = '{op, a, d};
      cmd_valid = 1'b1;
      step_clk();
      cmd_valid = 1'b0;
      saw_busy = 1'b0;
      if (!wait_rsp) return;
      for (i = 0; i < PT + 200 && rsp_valid !== 1'b1; i++) begin
         if (prog_busy === 1'b1) saw_busy = 1'b1;
         step_clk();
      end
      check(rsp_valid, 1'b1, "no response");
      got = rsp;
   endtask

   task automatic t_reset();
      repeat (20) step_clk();
      check({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe}, 4'hE, "idle pins in reset");
      check({flash_rst_n, cmd_ready, id_mode, prog_busy}, 4'h0, "outputs in reset");
      arst_n = 1'b1;
      step_clk();
      check({flash_rst_n, cmd_ready}, 2'h3, "after release");
   endtask

   task automatic t_ident(input logic bm);
      byte_mode = bm;
      run(OP_ID_ENTER, 26'h0000000, 16'h0000);
      check(id_mode, 1'b1, "entry");
      run(OP_READ, 26'h0000000, 16'h0000);
      check(got.data, lane(16'h005A), "maker code");
      run(OP_READ, 26'h0000000, 16'h0000);
      check(got.data, lane(16'h005A), "repeat read");
      run(OP_READ, 26'h0000003, 16'h0000);
      check(got.data, lane(16'h0099), "secure lock");
      run(OP_READ, 26'h0000022, 16'h0000);
      check(got.data, 16'h0001, "sector locked");
      run(OP_READ, 26'h0000012, 16'h0000);
      check(got.data, 16'h0000, "sector unlocked");
      run(OP_PROGRAM, 26'h0000040, 16'h0000);
      check({got.err, saw_busy}, 2'h2, "program refused");
      run(OP_ID_EXIT, 26'h3FFFFFF, 16'h0000);
      check({got.err, id_mode}, 2'h0, "exit");
      run(OP_READ, 26'h0000040, 16'h0000);
      check(got.data, lane(16'hFFFF), "array after exit");
   endtask

   task automatic t_program();
      byte_mode = 1'b0;
      run(OP_PROGRAM, 26'h00000C1, 16'h1234);
      check({got.err, saw_busy}, 2'h1, "program polled");
      run(OP_READ, 26'h00000C1, 16'h0000);
      check(got.data, 16'h1234, "readback");
      run(OP_PROGRAM, 26'h00000C1, 16'hFF0F);
      run(OP_READ, 26'h00000C1, 16'h0000);
      check(got.data, 16'h1204, "reprogram clears only");
      run(OP_PROGRAM, 26'h0000011, 16'h00FF);
      run(OP_READ, 26'h0000011, 16'h0000);
      check(got.data, 16'h00FF, "lower sector after higher");
      byte_mode = 1'b1;
      run(OP_PROGRAM, 26'h0000050, 16'hAB3C);
      run(OP_READ, 26'h0000050, 16'h0000);
      check(got.data, 16'h003C, "byte program");
   endtask

   // the flash stays busy far beyond the poll limit, so the controller must give up
   task automatic t_timeout();
      byte_mode = 1'b0;
      stall = 1'b1;
      run(OP_PROGRAM, 26'h0000060, 16'h00F0);
      check({got.err, saw_busy, prog_busy}, 3'h6, "program timeout");
      arst_n = 1'b0;
      step_clk();
      stall = 1'b0;
      arst_n = 1'b1;
      step_clk();
   endtask

   task automatic t_abort();
      int i;
      byte_mode = 1'b0;
      run(OP_PROGRAM, 26'h0000070, 16'h0F0F, 1'b0);
      for (i = 0; i < 100 && prog_busy !== 1'b1; i++) step_clk();
      check(prog_busy, 1'b1, "busy before abort");
      arst_n = 1'b0;
      #1;
      check({flash_rst_n, prog_busy, pins.ce_n}, 3'h1, "abort");
      repeat (3) step_clk();
      arst_n = 1'b1;
      step_clk();
      run(OP_PROGRAM, 26'h0000070, 16'h0F0F);
      check(got.err, 1'b0, "reissue");
      run(OP_READ, 26'h0000070, 16'h0000);
      check(got.data, 16'h0F0F, "data after reissue");
      check(proto_err, 0, "write framing");
   endtask

   initial begin
      #400000;
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end

   initial begin
      t_reset();
      t_ident(1'b0);
      t_ident(1'b1);
      t_program();
      t_timeout();
      t_abort();
      summarize();
   end
endmodule
